// >>> hw/secure_access_channel_unit.sv
// Secure access channel unit: Avalon slave with remapped, lockable channels
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
module secure_access_channel_unit
  import sacu_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [DATA_W-1:0] o_avs_readdata,
  output logic                   o_avs_waitrequest,
  output logic      [1:0]        o_avs_response,
  // Forwarding master towards protected registers
  output logic      [DATA_W-1:0] o_tgt_address,
  output logic                   o_tgt_read,
  output logic                   o_tgt_write,
  output logic      [DATA_W-1:0] o_tgt_writedata,
  output logic      [3:0]        o_tgt_byteenable,
  input  wire logic [DATA_W-1:0] i_tgt_readdata,
  input  wire logic              i_tgt_waitrequest,
  // Interrupt
  output logic                   o_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  bus_state_t              state;
  logic                    enabled;
  logic                    setup;
  logic                    berr_on;
  logic                    open_mode;
  logic [WIN_W-1:0]        win_len;
  logic                    open_valid;
  logic [CHAN_W-1:0]       open_idx;
  logic [WIN_W-1:0]        timer;
  logic [EVT_W-1:0]        status;
  logic [EVT_W-1:0]        mask;
  logic [DATA_W-1:0]       chan_target [CHAN_N];

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  logic                    req;
  logic                    wr_done;
  logic                    rd_done;
  logic                    hit_chan_reg;
  logic                    hit_chan_win;
  logic [CHAN_W-1:0]       ch;
  logic                    allowed;
  logic                    start_fwd;
  logic                    refuse;
  logic                    unlock_wr;
  logic [DATA_W-1:0]       be_mask;
  logic [DATA_W-1:0]       reg_rdata;
  logic                    reg_known;
  logic [EVT_W-1:0]        next_status;

  assign req          = (i_avs_read || i_avs_write) && state == ST_IDLE;
  // Writes and read side effects land on the edge where waitrequest is low
  assign wr_done      = state == ST_DONE && i_avs_write;
  assign rd_done      = state == ST_DONE && i_avs_read;
  assign hit_chan_reg = i_avs_address[ADDR_W-1:PAGE_LSB] == OFS_CHAN_TARGET[ADDR_W-1:PAGE_LSB];
  assign hit_chan_win = i_avs_address[ADDR_W-1:PAGE_LSB] == OFS_CHAN_WINDOW[ADDR_W-1:PAGE_LSB];
  assign ch           = i_avs_address[IDX_LSB+CHAN_W-1:IDX_LSB];
  assign allowed      = enabled && (open_mode || (open_valid && open_idx == ch));
  assign start_fwd    = req && hit_chan_win && allowed;
  assign refuse       = req && hit_chan_win && !allowed;
  assign unlock_wr    = wr_done && i_avs_address == OFS_UNLOCK && enabled && !open_mode;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[8*b +: 8] = {8{i_avs_byteenable[b]}};
    end
  end

  always_comb begin
    reg_known = 1'b1;
    reg_rdata = '0;
    if (hit_chan_reg) begin
      reg_rdata = chan_target[ch];
    end else begin
      case (i_avs_address)
        OFS_CONTROL, OFS_UNLOCK: reg_rdata = '0;
        OFS_STATUS:  reg_rdata[EVT_W-1:0] = status;
        OFS_MASK:    reg_rdata[EVT_W-1:0] = mask;
        OFS_CONFIG: begin
          reg_rdata[CFG_OPEN_BIT]              = open_mode;
          reg_rdata[CFG_WIN_LSB +: WIN_W]      = win_len;
        end
        OFS_STATE: begin
          reg_rdata[STA_ENABLED]               = enabled;
          reg_rdata[STA_SETUP]                 = setup;
          reg_rdata[STA_BERR]                  = berr_on;
          reg_rdata[STA_OPEN_VALID]            = open_valid;
          reg_rdata[STA_OPEN_LSB +: CHAN_W]    = open_idx;
        end
        OFS_VERSION: begin
          reg_rdata[$bits(MODULE_VERSION)-1:0]            = MODULE_VERSION;
          reg_rdata[VARIANT_LSB +: $bits(MODULE_VARIANT)] = MODULE_VARIANT;
        end
        default: reg_known = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus handler
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state             <= ST_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
      o_avs_response    <= RESP_OKAY;
      o_tgt_address     <= '0;
      o_tgt_read        <= 1'b0;
      o_tgt_write       <= 1'b0;
      o_tgt_writedata   <= '0;
      o_tgt_byteenable  <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_fwd) begin
            o_tgt_address    <= chan_target[ch];
            o_tgt_read       <= i_avs_read;
            o_tgt_write      <= i_avs_write;
            o_tgt_writedata  <= i_avs_writedata;
            o_tgt_byteenable <= i_avs_byteenable;
            state            <= ST_FWD;
          end else if (refuse) begin
            // Refused accesses reach nothing; error reply only when berr_on is set
            o_avs_readdata    <= '0;
            o_avs_response    <= berr_on ? RESP_SLVERR : RESP_OKAY;
            o_avs_waitrequest <= 1'b0;
            state             <= ST_DONE;
          end else if (req) begin
            o_avs_readdata    <= reg_rdata;
            o_avs_response    <= reg_known ? RESP_OKAY : RESP_SLVERR;
            o_avs_waitrequest <= 1'b0;
            state             <= ST_DONE;
          end
        end
        ST_FWD: begin
          if (!i_tgt_waitrequest) begin
            o_tgt_read        <= 1'b0;
            o_tgt_write       <= 1'b0;
            o_avs_readdata    <= i_tgt_readdata;
            o_avs_response    <= RESP_OKAY;
            o_avs_waitrequest <= 1'b0;
            state             <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_avs_waitrequest <= 1'b1;
          o_avs_response    <= RESP_OKAY;
          state             <= ST_IDLE;
        end
        default: begin
          o_avs_waitrequest <= 1'b1;
          o_tgt_read        <= 1'b0;
          o_tgt_write       <= 1'b0;
          state             <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register actions; off beats on, exit beats enter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enabled <= 1'b0;
      setup   <= 1'b0;
      berr_on <= 1'b0;
    end else if (wr_done && i_avs_address == OFS_CONTROL && i_avs_byteenable[0]) begin
      if (i_avs_writedata[unit_off_bit]) begin
        enabled <= 1'b0;
      end else if (i_avs_writedata[unit_on_bit]) begin
        enabled <= 1'b1;
      end
      if (i_avs_writedata[setup_exit_bit]) begin
        setup <= 1'b0;
      end else if (i_avs_writedata[setup_enter_bit]) begin
        setup <= 1'b1;
      end
      if (i_avs_writedata[bus_fault_resp_off]) begin
        berr_on <= 1'b0;
      end else if (i_avs_writedata[bus_fault_resp_on]) begin
        berr_on <= 1'b1;
      end
    end
  end

  // Config and mask
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      open_mode <= 1'b0;
      win_len   <= WIN_RESET;
      mask      <= '0;
    end else if (wr_done) begin
      if (i_avs_address == OFS_CONFIG) begin
        if (i_avs_byteenable[0]) begin
          open_mode <= i_avs_writedata[CFG_OPEN_BIT];
        end
        win_len <= (win_len & ~be_mask[CFG_WIN_LSB +: WIN_W])
                 | (i_avs_writedata[CFG_WIN_LSB +: WIN_W] & be_mask[CFG_WIN_LSB +: WIN_W]);
      end
      if (i_avs_address == OFS_MASK && i_avs_byteenable[0]) begin
        mask <= i_avs_writedata[EVT_W-1:0];
      end
    end
  end

  // Target address per channel, guarded by setup mode
  for (genvar g = 0; g < CHAN_N; g++) begin : g_chan
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        chan_target[g] <= '0;
      end else if (wr_done && setup && hit_chan_reg && ch == CHAN_W'(g)) begin
        chan_target[g] <= (chan_target[g] & ~be_mask) | (i_avs_writedata & be_mask);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Unlock window; an unlock grants one access only
  logic timeout;

  assign timeout = open_valid && !unlock_wr && !start_fwd && enabled && !open_mode
                   && timer <= WIN_W'(1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      open_valid <= 1'b0;
      open_idx   <= '0;
      timer      <= '0;
    end else if (unlock_wr) begin
      open_valid <= 1'b1;
      open_idx   <= i_avs_writedata[CHAN_W-1:0];
      timer      <= win_len;
    end else if (!enabled || open_mode || start_fwd || timeout) begin
      open_valid <= 1'b0;
      timer      <= '0;
    end else if (open_valid) begin
      timer      <= timer - WIN_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky events, cleared by reading; a new event wins over the clear
  always_comb begin
    next_status = status;
    if (rd_done && i_avs_address == OFS_STATUS) begin
      next_status = '0;
    end
    next_status[EVT_REFUSED] = next_status[EVT_REFUSED] | refuse;
    next_status[EVT_TIMEOUT] = next_status[EVT_TIMEOUT] | timeout;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status <= '0;
      o_irq  <= 1'b0;
    end else begin
      status <= next_status;
      o_irq  <= |(next_status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_ctrl_wr;
    wr_done && i_avs_address == OFS_CONTROL && i_avs_byteenable[0];
  endsequence

  sequence s_locked_hit;
    req && hit_chan_win && !allowed;
  endsequence

  a_ctrl_enable: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ctrl_wr and (i_avs_writedata[unit_on_bit] && !i_avs_writedata[unit_off_bit]) |=> enabled)
    else $error("enable write did not enable the unit");

  a_ctrl_disable: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ctrl_wr and i_avs_writedata[unit_off_bit] |=> !enabled ##1 !open_valid)
    else $error("disable write did not disable the unit");

  a_setup_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ctrl_wr and (i_avs_writedata[setup_enter_bit] && !i_avs_writedata[setup_exit_bit]) |=> setup)
    else $error("setup enter failed");

  a_setup_leave: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ctrl_wr and i_avs_writedata[setup_exit_bit] |=> !setup)
    else $error("setup exit failed");

  a_zero_write_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ctrl_wr and (i_avs_writedata[5:0] == 6'h00) |=> $stable(enabled) && $stable(setup) && $stable(berr_on))
    else $error("zero control write changed state");

  a_refuse_error: assert property (@(posedge i_clk) disable iff (i_rst)
    s_locked_hit and berr_on |=> !o_avs_waitrequest && o_avs_response == RESP_SLVERR && !o_tgt_read && !o_tgt_write)
    else $error("locked access not answered with bus error");

  a_refuse_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    s_locked_hit and !berr_on |=> o_avs_response == RESP_OKAY ##1 status[EVT_REFUSED])
    else $error("suppressed error response or event missing");

  a_unlock_opens: assert property (@(posedge i_clk) disable iff (i_rst)
    unlock_wr |=> open_valid && open_idx == $past(i_avs_writedata[CHAN_W-1:0]) && timer == $past(win_len))
    else $error("unlock did not open the chosen channel");

  a_timeout_relock: assert property (@(posedge i_clk) disable iff (i_rst)
    timeout |=> !open_valid && status[EVT_TIMEOUT] && (o_irq == mask[EVT_TIMEOUT] || o_irq))
    else $error("timeout did not relock and flag");

  a_open_mode_pass: assert property (@(posedge i_clk) disable iff (i_rst)
    req && hit_chan_win && enabled && open_mode |=> (o_tgt_read || o_tgt_write))
    else $error("open mode access not forwarded");

  a_target_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    start_fwd |=> o_tgt_address == $past(chan_target[ch]))
    else $error("forwarded to wrong target address");

  a_setup_guard: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_done && hit_chan_reg && !setup |=> chan_target[$past(ch)] == $past(chan_target[ch]))
    else $error("target address written outside setup mode");

  a_version_read: assert property (@(posedge i_clk) disable iff (i_rst)
    req && i_avs_read && i_avs_address == OFS_VERSION |=> o_avs_readdata[$bits(MODULE_VERSION)-1:0] == MODULE_VERSION
      && o_avs_readdata[VARIANT_LSB +: $bits(MODULE_VARIANT)] == MODULE_VARIANT)
    else $error("version register content wrong");

  // Open channel with time left and nothing else acting on it
  sequence s_window_tick;
    open_valid && enabled && !open_mode && !unlock_wr && !start_fwd && timer > WIN_W'(1);
  endsequence

  a_window_count: assert property (@(posedge i_clk) disable iff (i_rst)
    s_window_tick |=> open_valid && timer == $past(timer) - WIN_W'(1))
    else $error("unlock window did not count down");

  a_open_no_timeout: assert property (@(posedge i_clk) disable iff (i_rst)
    open_mode && enabled |-> !timeout && !refuse)
    else $error("open mode refused an access or timed out");

  a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst)
    o_irq == |(status & mask))
    else $error("interrupt does not follow masked status");

  a_wait_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule : secure_access_channel_unit

// >>> hw/sacu_pkg.sv
// Constants, register map and state encoding of the secure access channel unit
package sacu_pkg;
  // Bus geometry
  localparam int          ADDR_W          = 9;
  localparam int          DATA_W          = 32;
  localparam int          CHAN_N          = 8;
  localparam int          CHAN_W          = 3;
  localparam int          WIN_W           = 16;
  // Register byte offsets
  localparam logic [8:0]  OFS_CONTROL     = 9'h000;
  localparam logic [8:0]  OFS_UNLOCK      = 9'h004;
  localparam logic [8:0]  OFS_STATUS      = 9'h008;
  localparam logic [8:0]  OFS_MASK        = 9'h00C;
  localparam logic [8:0]  OFS_CONFIG      = 9'h010;
  localparam logic [8:0]  OFS_STATE       = 9'h014;
  localparam logic [8:0]  OFS_VERSION     = 9'h028;
  localparam logic [8:0]  OFS_CHAN_TARGET = 9'h040;
  localparam logic [8:0]  OFS_CHAN_WINDOW = 9'h100;
  // Page of eight words picked out by address bits 8:5
  localparam int          PAGE_LSB        = 5;
  localparam int          IDX_LSB         = 2;
  // Control bits, write one to act
  localparam int          unit_on_bit        = 0;
  localparam int          unit_off_bit       = 1;
  localparam int          setup_enter_bit    = 2;
  localparam int          setup_exit_bit     = 3;
  localparam int          bus_fault_resp_on  = 4;
  localparam int          bus_fault_resp_off = 5;
  // Config fields
  localparam int          CFG_OPEN_BIT    = 0;
  localparam int          CFG_WIN_LSB     = 16;
  localparam logic [15:0] WIN_RESET       = 16'h0100;
  // Status and mask layout
  localparam int          EVT_W           = 2;
  localparam int          EVT_REFUSED     = 0;
  localparam int          EVT_TIMEOUT     = 1;
  // State register layout
  localparam int          STA_ENABLED     = 0;
  localparam int          STA_SETUP       = 1;
  localparam int          STA_BERR        = 2;
  localparam int          STA_OPEN_VALID  = 3;
  localparam int          STA_OPEN_LSB    = 4;
  // Version register layout; values arbitrary
  localparam int          VARIANT_LSB     = 16;
  localparam logic [11:0] MODULE_VERSION  = 12'h101;
  localparam logic [3:0]  MODULE_VARIANT  = 4'h0;
  // Avalon response codes
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // Bus handler states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FWD  = 3'b010,
    ST_DONE = 3'b100
  } bus_state_t;
endpackage : sacu_pkg

// >>> bench/tgt_model.sv
// Behavioural protected register bank on the forwarding side
`timescale 1ns/1ns
module tgt_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Forwarded access
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_address,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic      [31:0] o_last_addr
);
  logic [31:0] mem [8];
  int          dly;
  ////////////////////////////////////////////////////////////////////////////
  // Random wait states; idle data toggles so stale values never look valid
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0;
      o_last_addr   <= 32'h0;
      dly           <= 0;
    end else if (o_waitrequest && (i_read || i_write) && dly == 0) begin
      o_waitrequest <= 1'b0;
      o_readdata    <= i_read ? mem[i_address[4:2]] : ~o_readdata;
      o_last_addr   <= i_address;
      dly           <= $urandom_range(3);
      if (i_write) mem[i_address[4:2]] <= i_writedata;
    end else begin
      o_waitrequest <= 1'b1;
      o_readdata    <= ~o_readdata;
      if ((i_read || i_write) && dly > 0) dly <= dly - 1;
    end
  end
endmodule : tgt_model

// >>> bench/secure_access_channel_unit_tb_top.sv
// Self-checking bench of the secure access channel unit
`timescale 1ns/1ns
module secure_access_channel_unit_tb_top;
  import sacu_pkg::*;
  logic              i_clk   = 1'b0;
  logic              i_rst   = 1'b1;
  logic [ADDR_W-1:0] av_addr = '0;
  logic              av_rd   = 1'b0;
  logic              av_wr   = 1'b0;
  logic [DATA_W-1:0] av_wd   = '0;
  logic [DATA_W-1:0] av_rdata, t_addr, t_wd, t_rdata, last_addr, d;
  logic              av_wait, t_rd, t_wr, t_wait, irq;
  logic [1:0]        av_resp;
  logic [3:0]        t_be;
  logic [31:0]       tgt [CHAN_N];
  logic [31:0]       dat [CHAN_N];
  logic [5:0]        seq [9] = '{6'h01, 6'h04, 6'h10, 6'h00, 6'h08, 6'h20, 6'h02, 6'h3F, 6'h15};
  logic [2:0]        st = 3'h0;
  int                err_count = 0;
  int                checks = 0;
  int                cyc = 0;
  always #4 i_clk = ~i_clk;
  secure_access_channel_unit u_secure_access_channel_unit (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .i_avs_byteenable(4'hF), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .o_avs_response(av_resp), .o_tgt_address(t_addr), .o_tgt_read(t_rd), .o_tgt_write(t_wr),
    .o_tgt_writedata(t_wd), .o_tgt_byteenable(t_be), .i_tgt_readdata(t_rdata), .i_tgt_waitrequest(t_wait),
    .o_irq(irq));
  tgt_model u_tgt_model (
    .i_clk(i_clk), .i_rst(i_rst), .i_read(t_rd), .i_write(t_wr), .i_address(t_addr), .i_writedata(t_wd),
    .o_readdata(t_rdata), .o_waitrequest(t_wait), .o_last_addr(last_addr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_flag
  // Expected enable, setup and bus-error state; off and exit bits win a pair
  function automatic logic [2:0] exp_state(input logic [2:0] c, input logic [5:0] w);
    logic [2:0] n;
    n = c;
    if (w[unit_on_bit]) n[STA_ENABLED] = 1'b1;
    if (w[unit_off_bit]) n[STA_ENABLED] = 1'b0;
    if (w[setup_enter_bit]) n[STA_SETUP] = 1'b1;
    if (w[setup_exit_bit]) n[STA_SETUP] = 1'b0;
    if (w[bus_fault_resp_on]) n[STA_BERR] = 1'b1;
    if (w[bus_fault_resp_off]) n[STA_BERR] = 1'b0;
    return n;
  endfunction : exp_state
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] wd, input logic [31:0] er,
                     input logic [1:0] es);
    int n;
    n = 0;
    @(posedge i_clk);
    av_addr <= a;
    av_wd   <= wd;
    av_wr   <= w;
    av_rd   <= ~w;
    do begin
      @(posedge i_clk);
      n++;
    end while (av_wait !== 1'b0 && n < 64);
    if (n >= 64) err_count++;
    chk_word({30'h0, av_resp}, {30'h0, es});
    if (!w) chk_word(av_rdata, er);
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : acc
  task automatic ctl(input logic [5:0] w);
    acc(1'b1, OFS_CONTROL, {26'h0, w}, 32'h0, RESP_OKAY);
    st = exp_state(st, w);
  endtask : ctl
  task automatic unl(input logic [2:0] c);
    acc(1'b1, OFS_UNLOCK, {29'h0, c}, 32'h0, RESP_OKAY);
  endtask : unl
  function automatic logic [8:0] win(input int c);
    return OFS_CHAN_WINDOW + 9'(c * 4);
  endfunction : win
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(9988));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    acc(1'b0, OFS_VERSION, 0, {12'h0, MODULE_VARIANT, 4'h0, MODULE_VERSION}, RESP_OKAY);
    acc(1'b0, OFS_CONTROL, 0, 32'h0, RESP_OKAY);
    acc(1'b0, OFS_STATE, 0, 32'h0, RESP_OKAY);
    acc(1'b0, 9'h030, 0, 32'h0, RESP_SLVERR);
    $display("test reset_map done");
    for (int i = 0; i < 13; i++) begin
      d = (i < 9) ? {26'h0, seq[i]} : {26'h0, 6'($urandom)};
      ctl(d[5:0]);
      acc(1'b0, OFS_STATE, 0, {29'h0, st}, RESP_OKAY);
    end
    ctl(6'h15);
    acc(1'b1, OFS_MASK, 32'h3, 32'h0, RESP_OKAY);
    // Six cycles: unlock, state read and access fit, timeout still lands inside the wait below
    acc(1'b1, OFS_CONFIG, 32'h0006_0000, 32'h0, RESP_OKAY);
    acc(1'b0, OFS_CONFIG, 0, 32'h0006_0000, RESP_OKAY);
    $display("test control done");
    for (int c = 0; c < CHAN_N; c++) begin
      tgt[c] = ($urandom & 32'hFFFF_FFE0) | (c << 2);
      acc(1'b1, OFS_CHAN_TARGET + 9'(c * 4), tgt[c], 32'h0, RESP_OKAY);
    end
    ctl(6'h08);
    acc(1'b1, OFS_CHAN_TARGET, ~tgt[0], 32'h0, RESP_OKAY);
    for (int c = 0; c < CHAN_N; c++) acc(1'b0, OFS_CHAN_TARGET + 9'(c * 4), 0, tgt[c], RESP_OKAY);
    $display("test targets done");
    d = last_addr;
    acc(1'b0, win(2), 0, 32'h0, RESP_SLVERR);
    chk_word(last_addr, d);
    repeat (2) @(posedge i_clk);
    chk_flag(irq, 1'b1);
    acc(1'b0, OFS_STATUS, 0, 32'h1, RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk_flag(irq, 1'b0);
    $display("test refused done");
    for (int k = 0; k < 4; k++) begin
      automatic logic [2:0] c = 3'($urandom);
      unl(c);
      acc(1'b0, OFS_STATE, 0, {25'h0, c, 1'b1, st}, RESP_OKAY);
      d = $urandom;
      dat[c] = d;
      acc(1'b1, win(c), d, 32'h0, RESP_OKAY);
      chk_word(last_addr, tgt[c]);
      chk_word({28'h0, t_be}, 32'h0000_000F);
      unl(c);
      acc(1'b0, win(c), 0, d, RESP_OKAY);
      acc(1'b0, win(c), 0, 32'h0, RESP_SLVERR);
    end
    unl(3'h1);
    unl(3'h6);
    acc(1'b0, win(1), 0, 32'h0, RESP_SLVERR);
    acc(1'b1, win(6), 32'h0, 32'h0, RESP_OKAY);
    acc(1'b0, OFS_STATUS, 0, 32'h1, RESP_OKAY);
    $display("test unlock done");
    unl(3'h4);
    repeat (8) @(posedge i_clk);
    chk_flag(irq, 1'b1);
    // Channel index field keeps the last opened channel after relock
    acc(1'b0, OFS_STATE, 0, {25'h0, 3'h4, 1'b0, st}, RESP_OKAY);
    acc(1'b0, OFS_STATUS, 0, 32'h2, RESP_OKAY);
    acc(1'b0, win(4), 0, 32'h0, RESP_SLVERR);
    acc(1'b0, OFS_STATUS, 0, 32'h1, RESP_OKAY);
    $display("test timeout done");
    ctl(6'h20);
    acc(1'b1, OFS_MASK, 32'h2, 32'h0, RESP_OKAY);
    acc(1'b0, win(0), 0, 32'h0, RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk_flag(irq, 1'b0);
    acc(1'b0, OFS_STATUS, 0, 32'h1, RESP_OKAY);
    ctl(6'h10);
    acc(1'b1, OFS_MASK, 32'h3, 32'h0, RESP_OKAY);
    $display("test bus_error_off done");
    acc(1'b1, OFS_CONFIG, 32'h0006_0001, 32'h0, RESP_OKAY);
    for (int c = 0; c < CHAN_N; c++) begin
      dat[c] = $urandom;
      acc(1'b1, win(c), dat[c], 32'h0, RESP_OKAY);
    end
    repeat (10) @(posedge i_clk);
    for (int c = 0; c < CHAN_N; c++) acc(1'b0, win(c), 0, dat[c], RESP_OKAY);
    acc(1'b0, OFS_STATUS, 0, 32'h0, RESP_OKAY);
    $display("test open_mode done");
    ctl(6'h02);
    acc(1'b0, win(0), 0, 32'h0, RESP_SLVERR);
    $display("test disable done");
    tally_and_finish();
  end
endmodule : secure_access_channel_unit_tb_top
